// ---- rtl/usx_consts.svh ----
/*
  register map, field positions and reset values of the serial transceiver.
  assumes inclusion by bare name from core and testbench.
*/
`ifndef USX_CONSTS_SVH
`define USX_CONSTS_SVH
`define USX_OFF_DATA 8'h00
`define USX_OFF_CSA 8'h04
`define USX_OFF_CSB 8'h08
`define USX_OFF_CSC 8'h0c
`define USX_OFF_BAUD 8'h10
`define USX_A_RXC 7
`define USX_A_TXC 6
`define USX_A_TX_BUFFER_EMPTY_FLAG 5
`define USX_A_FE 4
`define USX_A_OVR 3
`define USX_A_U2X 1
`define USX_B_DONE_IE 6
`define USX_B_EMPTY_IE 5
`define USX_B_RXON 4
`define USX_B_TXON 3
`define USX_B_SZ2 2
`define USX_B_RX9 1
`define USX_B_TX9 0
`define USX_C_DIR 7
`define USX_C_SYNC 6
`define USX_C_PEN 5
`define USX_C_PODD 4
`define USX_C_STOP2 3
`define USX_C_SZ_HI 2
`define USX_C_SZ_LO 1
`define USX_C_RESET 8'h06
`define USX_OS_NORM 5'h10
`define USX_OS_DBL 5'h08
`define USX_RESP_OK 2'h0
`define USX_RESP_ERR 2'h2
`endif

// ---- rtl/usx_pkg.sv ----
/*
  types shared by the serial transceiver.
  assumes usx_consts.svh is on the include path.
*/
package usx_pkg;
  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic ovr;
  } usx_rx_ent_t;
  typedef enum logic [2:0] {TX_IDLE, TX_DATA, TX_PAR, TX_STOP, TX_LAST} usx_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HOLD} usx_rx_st_t;
endpackage

// ---- rtl/usx_core.sv ----
/*
  serial transceiver core: axi4-lite registers, baud and clock-pin logic,
  transmitter with parity, receiver with two-entry fifo plus held shift level.
  assumes pins are raw (synchronised here) and one 250 mhz core clock.
*/
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "usx_consts.svh"
// Notes on behaviour
// - two-entry receive fifo; each data read of a non-empty fifo pops exactly one character.
// - frame error, overrun and ninth bit travel with their character.
// - full fifo keeps frame in shift register; overrun only on next start.
// - four clock modes; sync select bit picks async or sync.
// - double speed acts only in asynchronous operation.
// - in sync mode clock pin direction picks master or slave.
// - clock pin is driven by transceiver only in synchronous operation.
// - buffer-empty flag set while empty, cleared by data register write.
// - empty request stays high while flag, enable and global enable hold.
// - done flag sets when frame shifted out and buffer is empty.
// - done flag clears on service or write of one; zero does nothing.
// - done request when flag set, enable set and global enable set.
// - parity bit inserted after last data bit, before first stop bit.
// - transmitter off only after shifter and buffer drain; then releases pin.
// - receiver on overrides receive pin as serial input.
// - in sync mode receiver samples on rising clock pin edges.
// - 5 to 9 data bits from valid start to first stop; second ignored.
// - first stop bit moves frame from shifter into receive buffer.
// - divisor zero gives fastest rate, core clock over 16 or 8 async, over 2 as sync master.
module usx_core import usx_pkg::*; #(
  parameter int BAUD_W = 12
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic GIE_IN,
  input wire logic DONE_ACK_IN,
  output logic EMPTY_IRQ_OUT,
  output logic DONE_IRQ_OUT,
  input wire logic RXD_IN,
  output logic RXD_OVERRIDE_OUT,
  output logic TXD_OUT,
  output logic TXD_OE_OUT,
  input wire logic XCK_IN,
  output logic XCK_OUT,
  output logic XCK_OE_OUT
);
  if (BAUD_W < 1 || BAUD_W > 16) begin : g_bad_baud_w
    $error("usx_core: BAUD_W out of range");
  end

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  logic aw_v_q, aw_v_d, w_v_q, w_v_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] aw_a_q, aw_a_d, wd_q, wd_d;
  logic ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  logic wr_en, ar_hs, rd_pop;
  logic [7:0] csa_r, csb_r, csc_q, csc_d, csb_q, csb_d;
  logic u2x_q, u2x_d;
  logic [BAUD_W-1:0] div_q, div_d;
  logic [1:0] f_cnt_q;
  usx_rx_ent_t head;
  logic txc_q, tx_bv_q;

  assign S_AXI_AWREADY_OUT = !aw_v_q && !bv_q;
  assign S_AXI_WREADY_OUT = !w_v_q && !bv_q;
  assign S_AXI_ARREADY_OUT = !rv_q;
  assign S_AXI_BVALID_OUT = bv_q;
  assign S_AXI_BRESP_OUT = br_q;
  assign S_AXI_RVALID_OUT = rv_q;
  assign S_AXI_RDATA_OUT = rd_q;
  assign S_AXI_RRESP_OUT = rr_q;
  assign wr_en = aw_v_q && w_v_q && !bv_q;
  assign ar_hs = S_AXI_ARVALID_IN && !rv_q;
  // the pop rides on the read itself, so status must be read first
  assign rd_pop = ar_hs && S_AXI_ARADDR_IN == `USX_OFF_DATA && f_cnt_q != 2'h0;

  always_comb begin
    csa_r = 8'h00;
    csa_r[`USX_A_RXC] = f_cnt_q != 2'h0;
    csa_r[`USX_A_TXC] = txc_q;
    csa_r[`USX_A_TX_BUFFER_EMPTY_FLAG] = !tx_bv_q;
    csa_r[`USX_A_FE] = head.fe;
    csa_r[`USX_A_OVR] = head.ovr;
    csa_r[`USX_A_U2X] = u2x_q;
    csb_r = csb_q;
    csb_r[`USX_B_RX9] = head.data[8];
  end

  always_comb begin
    aw_v_d = aw_v_q;
    aw_a_d = aw_a_q;
    w_v_d = w_v_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      aw_v_d = 1'b1;
      aw_a_d = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      w_v_d = 1'b1;
      wd_d = S_AXI_WDATA_IN[7:0];
      ws_d = S_AXI_WSTRB_IN[0];
    end
    if (wr_en) begin
      aw_v_d = 1'b0;
      w_v_d = 1'b0;
      bv_d = 1'b1;
      br_d = (aw_a_q <= `USX_OFF_BAUD && aw_a_q[1:0] == 2'h0) ? `USX_RESP_OK : `USX_RESP_ERR;
    end
    if (bv_q && S_AXI_BREADY_IN) bv_d = 1'b0;
    if (rv_q && S_AXI_RREADY_IN) rv_d = 1'b0;
    if (ar_hs) begin
      rv_d = 1'b1;
      rr_d = `USX_RESP_OK;
      rd_d = 32'h0;
      case (S_AXI_ARADDR_IN)
        `USX_OFF_DATA: rd_d[7:0] = head.data[7:0];
        `USX_OFF_CSA: rd_d[7:0] = csa_r;
        `USX_OFF_CSB: rd_d[7:0] = csb_r;
        `USX_OFF_CSC: rd_d[7:0] = csc_q;
        `USX_OFF_BAUD: rd_d[BAUD_W-1:0] = div_q;
        default: rr_d = `USX_RESP_ERR;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      aw_v_q <= 1'b0;
      aw_a_q <= 8'h00;
      w_v_q <= 1'b0;
      wd_q <= 8'h00;
      ws_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= 2'h0;
      rv_q <= 1'b0;
      rd_q <= 32'h0;
      rr_q <= 2'h0;
    end else begin
      aw_v_q <= aw_v_d;
      aw_a_q <= aw_a_d;
      w_v_q <= w_v_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
    end
  end

  // ------------------------------------------------------------
  // control registers and clock generation
  // ------------------------------------------------------------
  logic wr_lo, wr_data, wr_csa;
  logic [BAUD_W-1:0] bd_q, bd_d;
  logic tick, xi_q, xi_d, xs1_q, xs2_q, xp_q, xe, rise, fall;
  logic sync_m, master, txon, rxon, pen;
  logic [4:0] os_n;
  logic [3:0] nbits;

  assign wr_lo = wr_en && ws_q;
  assign wr_data = wr_lo && aw_a_q == `USX_OFF_DATA;
  assign wr_csa = wr_lo && aw_a_q == `USX_OFF_CSA;
  assign sync_m = csc_q[`USX_C_SYNC];
  assign master = sync_m && csc_q[`USX_C_DIR];
  assign txon = csb_q[`USX_B_TXON];
  assign rxon = csb_q[`USX_B_RXON];
  assign pen = csc_q[`USX_C_PEN];
  assign os_n = sync_m ? 5'h01 : (u2x_q ? `USX_OS_DBL : `USX_OS_NORM);
  assign nbits = (csb_q[`USX_B_SZ2] && csc_q[`USX_C_SZ_HI] && csc_q[`USX_C_SZ_LO]) ? 4'h9
    : 4'h5 + {2'h0, csc_q[`USX_C_SZ_HI], csc_q[`USX_C_SZ_LO]};
  // >= lets a lowered divisor take effect without waiting for a counter wrap
  assign tick = bd_q >= div_q;
  assign xe = master ? xi_q : xs2_q;
  assign rise = xe && !xp_q;
  assign fall = !xe && xp_q;
  assign XCK_OUT = xi_q;
  assign XCK_OE_OUT = master;
  assign RXD_OVERRIDE_OUT = rxon;

  always_comb begin
    csb_d = csb_q;
    csc_d = csc_q;
    u2x_d = u2x_q;
    div_d = div_q;
    bd_d = tick ? '0 : bd_q + 1'b1;
    xi_d = xi_q;
    if (master && tick) xi_d = !xi_q;
    if (!master) xi_d = 1'b0;
    if (wr_csa) u2x_d = wd_q[`USX_A_U2X];
    if (wr_lo && aw_a_q == `USX_OFF_CSB) csb_d = wd_q;
    if (wr_lo && aw_a_q == `USX_OFF_CSC) csc_d = wd_q;
    if (wr_lo && aw_a_q == `USX_OFF_BAUD) div_d = BAUD_W'(wd_q);
    csb_d[`USX_B_RX9] = 1'b0;
  end

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      csb_q <= 8'h00;
      csc_q <= `USX_C_RESET;
      u2x_q <= 1'b0;
      div_q <= '0;
      bd_q <= '0;
      xi_q <= 1'b0;
      xs1_q <= 1'b0;
      xs2_q <= 1'b0;
      xp_q <= 1'b0;
    end else begin
      csb_q <= csb_d;
      csc_q <= csc_d;
      u2x_q <= u2x_d;
      div_q <= div_d;
      bd_q <= bd_d;
      xi_q <= xi_d;
      xs1_q <= XCK_IN;
      xs2_q <= xs1_q;
      xp_q <= xe;
    end
  end

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  usx_tx_st_t tst_q, tst_d;
  logic [8:0] tsh_q, tsh_d, tbuf_q, tbuf_d;
  logic [3:0] tcnt_q, tcnt_d, tos_q, tos_d;
  logic tbv_d, txc_d, tpar_q, tpar_d, txd_q, txd_d, toe_q, toe_d, ttick, tload;

  logic tbv_q_w;
  assign tx_bv_q = tbv_q_w;
  // async bit pace; master and slave shift on the falling clock edge
  assign ttick = sync_m ? fall : (tick && tos_q == 4'(os_n - 5'h01));
  // a disable waits for the drain, so a pending buffer still goes out
  assign tload = tbv_q_w && (txon || toe_q);
  assign TXD_OUT = txd_q;
  assign TXD_OE_OUT = toe_q;
  assign EMPTY_IRQ_OUT = csb_q[`USX_B_EMPTY_IE] && !tbv_q_w && GIE_IN;
  assign DONE_IRQ_OUT = csb_q[`USX_B_DONE_IE] && txc_q && GIE_IN;

  always_comb begin
    tst_d = tst_q;
    tsh_d = tsh_q;
    tbuf_d = tbuf_q;
    tbv_d = tbv_q_w;
    tcnt_d = tcnt_q;
    tpar_d = tpar_q;
    txd_d = txd_q;
    txc_d = txc_q;
    tos_d = tos_q;
    if (tick) tos_d = (tos_q == 4'(os_n - 5'h01)) ? 4'h0 : tos_q + 4'h1;
    // a write to a full buffer is dropped, software must wait for empty
    if (wr_data && !tbv_q_w) begin
      tbuf_d = {csb_q[`USX_B_TX9], wd_q};
      tbv_d = 1'b1;
    end
    if (DONE_ACK_IN || (wr_csa && wd_q[`USX_A_TXC])) txc_d = 1'b0;
    if (ttick) begin
      case (tst_q)
        TX_IDLE, TX_LAST: begin
          if (tload) begin
            txd_d = 1'b0;
            tsh_d = tbuf_q;
            tpar_d = ^(tbuf_q & ~(9'h1ff << nbits)) ^ csc_q[`USX_C_PODD];
            tbv_d = 1'b0;
            tcnt_d = 4'h0;
            tst_d = TX_DATA;
          end else begin
            if (tst_q == TX_LAST) txc_d = 1'b1;
            tst_d = TX_IDLE;
          end
        end
        TX_DATA: begin
          txd_d = tsh_q[0];
          tsh_d = {1'b0, tsh_q[8:1]};
          tcnt_d = tcnt_q + 4'h1;
          if (tcnt_q == nbits - 4'h1) tst_d = pen ? TX_PAR : TX_STOP;
        end
        TX_PAR: begin
          txd_d = tpar_q;
          tst_d = TX_STOP;
        end
        TX_STOP: begin
          txd_d = 1'b1;
          tcnt_d = 4'h0;
          if (tcnt_q == 4'h0 && csc_q[`USX_C_STOP2]) tcnt_d = 4'h1;
          else tst_d = TX_LAST;
        end
        default: tst_d = TX_IDLE;
      endcase
    end
    // pin override outlives the enable until nothing is left to send
    toe_d = txon || (toe_q && (tst_q != TX_IDLE || tbv_q_w));
  end

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      tst_q <= TX_IDLE;
      tsh_q <= 9'h000;
      tbuf_q <= 9'h000;
      tbv_q_w <= 1'b0;
      tcnt_q <= 4'h0;
      tpar_q <= 1'b0;
      txd_q <= 1'b1;
      txc_q <= 1'b0;
      tos_q <= 4'h0;
      toe_q <= 1'b0;
    end else begin
      tst_q <= tst_d;
      tsh_q <= tsh_d;
      tbuf_q <= tbuf_d;
      tbv_q_w <= tbv_d;
      tcnt_q <= tcnt_d;
      tpar_q <= tpar_d;
      txd_q <= txd_d;
      txc_q <= txc_d;
      tos_q <= tos_d;
      toe_q <= toe_d;
    end
  end

  // ------------------------------------------------------------
  // receiver and fifo
  // ------------------------------------------------------------
  usx_rx_st_t rst_q, rst_d;
  logic rs1_q, rs2_q, rtick, push, rfe_q, rfe_d, ovp_q, ovp_d;
  logic [8:0] rsh_q, rsh_d;
  logic [3:0] rbit_q, rbit_d;
  logic [4:0] ros_q, ros_d;
  usx_rx_ent_t fifo_q [2];
  usx_rx_ent_t fifo_d [2];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] f_cnt_d;

  assign rtick = sync_m ? rise : tick;
  assign head = fifo_q[rp_q];

  always_comb begin
    rst_d = rst_q;
    rsh_d = rsh_q;
    rbit_d = rbit_q;
    ros_d = ros_q;
    rfe_d = rfe_q;
    ovp_d = ovp_q;
    push = 1'b0;
    case (rst_q)
      RX_IDLE: if (rtick && !rs2_q) begin
        rsh_d = 9'h000;
        rbit_d = 4'h0;
        ros_d = 5'h00;
        rst_d = sync_m ? RX_DATA : RX_START;
      end
      RX_START: if (rtick) begin
        ros_d = ros_q + 5'h01;
        if (ros_q == (os_n >> 1) - 5'h01) begin
          ros_d = 5'h00;
          rst_d = rs2_q ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA, RX_PAR, RX_STOP: if (rtick) begin
        ros_d = ros_q + 5'h01;
        if (ros_q == os_n - 5'h01) begin
          ros_d = 5'h00;
          if (rst_q == RX_DATA) begin
            rsh_d[rbit_q] = rs2_q;
            rbit_d = rbit_q + 4'h1;
            if (rbit_q == nbits - 4'h1) rst_d = pen ? RX_PAR : RX_STOP;
          end else if (rst_q == RX_PAR) begin
            rst_d = RX_STOP;
          end else begin
            rfe_d = !rs2_q;
            rst_d = RX_HOLD;
          end
        end
      end
      RX_HOLD: begin
        if (f_cnt_q != 2'h2 || rd_pop) begin
          push = 1'b1;
          rst_d = RX_IDLE;
        end else if (rtick && !rs2_q) begin
          ovp_d = 1'b1;
          rsh_d = 9'h000;
          rbit_d = 4'h0;
          ros_d = 5'h00;
          rst_d = sync_m ? RX_DATA : RX_START;
        end
      end
      default: rst_d = RX_IDLE;
    endcase
    if (push) ovp_d = 1'b0;
    if (!rxon) rst_d = RX_IDLE;
  end

  always_comb begin
    wp_d = push ? !wp_q : wp_q;
    rp_d = rd_pop ? !rp_q : rp_q;
    f_cnt_d = f_cnt_q + {1'b0, push} - {1'b0, rd_pop};
    for (int i = 0; i < 2; i++) begin
      fifo_d[i] = fifo_q[i];
      if (push && wp_q == 1'(i)) fifo_d[i] = '{data: rsh_q, fe: rfe_q, ovr: ovp_q};
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rst_q <= RX_IDLE;
      rsh_q <= 9'h000;
      rbit_q <= 4'h0;
      ros_q <= 5'h00;
      rfe_q <= 1'b0;
      ovp_q <= 1'b0;
      rs1_q <= 1'b1;
      rs2_q <= 1'b1;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      f_cnt_q <= 2'h0;
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
    end else begin
      rst_q <= rst_d;
      rsh_q <= rsh_d;
      rbit_q <= rbit_d;
      ros_q <= ros_d;
      rfe_q <= rfe_d;
      ovp_q <= ovp_d;
      rs1_q <= RXD_IN;
      rs2_q <= rs1_q;
      wp_q <= wp_d;
      rp_q <= rp_d;
      f_cnt_q <= f_cnt_d;
      fifo_q <= fifo_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);

  AST_TX_BUFFER_EMPTY_FLAG_CLEAR: assert property (
    wr_data && !tbv_q_w |=> !csa_r[`USX_A_TX_BUFFER_EMPTY_FLAG]) else $error("empty flag not cleared");
  AST_EMPTY_REQ: assert property (
    !tbv_q_w && csb_q[`USX_B_EMPTY_IE] && GIE_IN |-> EMPTY_IRQ_OUT)
    else $error("empty request missing");
  AST_DONE_SET: assert property (
    ttick && tst_q == TX_LAST && !tload |=> txc_q && tst_q == TX_IDLE)
    else $error("done flag not set");
  AST_DONE_W0: assert property (
    wr_csa && !wd_q[`USX_A_TXC] && !DONE_ACK_IN && txc_q |=> txc_q)
    else $error("zero write cleared done flag");
  AST_DONE_REQ: assert property (
    $rose(txc_q) && csb_q[`USX_B_DONE_IE] && GIE_IN |-> DONE_IRQ_OUT)
    else $error("done request missing");
  AST_TX_DRAIN: assert property (
    $fell(txon) && (tst_q != TX_IDLE || tbv_q_w) |=> TXD_OE_OUT)
    else $error("pin released before drain");
  AST_FIFO_DEPTH: assert property (
    f_cnt_q != 2'h3) else $error("fifo over two entries");
  AST_HOLD_LEAVE: assert property (
    rst_q == RX_HOLD && f_cnt_q != 2'h2 |=> rst_q != RX_HOLD
      && f_cnt_q == $past(f_cnt_q) + 2'h1 - 2'($past(rd_pop)))
    else $error("held frame not moved");
  AST_OVR_CAUSE: assert property (
    $rose(ovp_q) |-> $past(rst_q) == RX_HOLD && $past(f_cnt_q) == 2'h2)
    else $error("overrun without full fifo");
  AST_XCK_ASYNC: assert property (
    !sync_m |-> !XCK_OE_OUT) else $error("clock pin driven in async mode");
  AST_MAX_RATE: assert property (
    div_q == '0 && !(wr_lo && aw_a_q == `USX_OFF_BAUD) |=> tick) else $error("no tick each cycle");
  COV_TX_FRAME: cover property (tst_q == TX_LAST ##1 txc_q);
  COV_RX_OVR: cover property ($rose(ovp_q));
  COV_SYNC_RX: cover property (sync_m && push);
endmodule

// ---- tb/usx_remote.sv ----
/*
  remote serial device: sends frames into the receiver, decodes frames from the transmitter.
  assumes the core clock for async bit timing and an idle-high line that the sender drives high between frames.
*/
`timescale 1ns/10ps
module usx_remote (
  input wire logic clk_in,
  input wire logic txd_in,
  output logic rxd_out,
  output logic xck_out
);
  int bit_cyc = 16;
  logic [9:0] got_q[$];
  logic [9:0] cap;
  initial begin
    rxd_out = 1'b1;
    xck_out = 1'b0;
  end
  // ----------------------------------------
  // frame sender
  // ----------------------------------------
  // clock stands low outside frames; sync data moves well away from the rising edge
  task automatic send(input logic [8:0] v, input int n, input bit sync);
    logic b;
    #1;
    for (int i = 0; i <= n + 1; i++) begin
      b = (i == 0) ? 1'b0 : (i > n) ? 1'b1 : v[i-1];
      if (sync) begin
        rxd_out = b;
        #24 xck_out = 1'b1;
        #24 xck_out = 1'b0;
      end else begin
        rxd_out <= b;
        repeat (bit_cyc) @(posedge clk_in);
      end
    end
  endtask
  // ----------------------------------------
  // frame decoder
  // ----------------------------------------
  // mid-bit sampling: a wrong bit rate garbles data, parity or stop
  always begin
    @(negedge txd_in);
    repeat (bit_cyc / 2) @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin
      repeat (bit_cyc) @(posedge clk_in);
      cap[i] = txd_in;
    end
    got_q.push_back(cap);
  end
endmodule

// ---- tb/tb_usx_core.sv ----
/*
  testbench of the serial transceiver: axi4-lite register tasks, remote serial device.
  assumes the 250 mhz core clock and the register map of usx_consts.svh.
*/
`timescale 1ns/10ps
`include "usx_consts.svh"
module tb_usx_core;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, gie = 1'b0, ack = 1'b0;
  logic awrdy, wrdy, bv, arrdy, rv, eirq, dirq, rxd, rxo, txd, txoe, serial_clock_pin, xcko, xckoe;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic xck_was;
  int miscompares = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  usx_core dut_u (
    .CORE_CLK_IN(clk), .RESET_IN(rst), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awrdy), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bre), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arrdy), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rre), .GIE_IN(gie),
    .DONE_ACK_IN(ack), .EMPTY_IRQ_OUT(eirq), .DONE_IRQ_OUT(dirq), .RXD_IN(rxd),
    .RXD_OVERRIDE_OUT(rxo), .TXD_OUT(txd), .TXD_OE_OUT(txoe), .XCK_IN(serial_clock_pin),
    .XCK_OUT(xcko), .XCK_OE_OUT(xckoe)
  );
  usx_remote rem_u (.clk_in(clk), .txd_in(txd), .rxd_out(rxd), .xck_out(serial_clock_pin));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // address and data are offered together and each dropped once taken
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw;
    bit w;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    do begin
      @(posedge clk);
      if (aw && awrdy) begin
        aw = 1'b0;
        awv <= 1'b0;
      end
      if (w && wrdy) begin
        w = 1'b0;
        wv <= 1'b0;
      end
    end while (!bv);
    rsp = bresp;
    bre <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk); while (!arrdy);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rd = rdata;
    rsp = rresp;
    rre <= 1'b0;
  endtask
  function automatic logic [8:0] pk(input logic [7:0] d);
    return {^d, d};
  endfunction
  task automatic rx_wait(input int n);
    for (int i = 0; i < 4000 && rem_u.got_q.size() < n; i++) @(posedge clk);
    chk("frames seen", n, rem_u.got_q.size());
  endtask
  task automatic frm(input logic [7:0] d);
    chk("tx frame", {22'h0, 1'b1, pk(d)}, {22'h0, rem_u.got_q.pop_front()});
  endtask
  task automatic final_report();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    reg_rd(`USX_OFF_CSC);
    chk("csc reset", `USX_C_RESET, rd);
    reg_rd(`USX_OFF_CSB);
    chk("csb reset", 32'h0, rd);
    reg_rd(`USX_OFF_CSA);
    chk("csa reset", 32'h20, rd);
    reg_rd(8'h14);
    chk("unmapped read", `USX_RESP_ERR, rsp);
    reg_wr(8'h14, 32'hff);
    chk("unmapped write", `USX_RESP_ERR, rsp);
    reg_wr(`USX_OFF_BAUD, 32'h0);
    reg_wr(`USX_OFF_CSC, 32'h26);
    reg_wr(`USX_OFF_CSB, 32'h78);
    chk("rx override", 1, rxo);
    gie <= 1'b1;
    @(posedge clk);
    chk("empty irq", 1, eirq);
    gie <= 1'b0;
    @(posedge clk);
    chk("empty irq masked", 0, eirq);
    gie <= 1'b1;
    // second byte waits in the buffer while the first shifts out
    reg_wr(`USX_OFF_DATA, 32'ha5);
    repeat (20) @(posedge clk);
    reg_wr(`USX_OFF_DATA, 32'h3c);
    reg_rd(`USX_OFF_CSA);
    chk("buffer empty bit", 0, rd & 32'h20);
    chk("empty irq busy", 0, eirq);
    rx_wait(2);
    frm(8'ha5);
    frm(8'h3c);
    repeat (16) @(posedge clk);
    reg_rd(`USX_OFF_CSA);
    chk("done and empty", 32'h60, rd & 32'h60);
    chk("done irq", 1, dirq);
    reg_wr(`USX_OFF_CSA, 32'h00);
    reg_rd(`USX_OFF_CSA);
    chk("done after zero", 32'h40, rd & 32'h40);
    reg_wr(`USX_OFF_CSA, 32'h40);
    reg_rd(`USX_OFF_CSA);
    chk("done after one", 0, rd & 32'h40);
    reg_wr(`USX_OFF_DATA, 32'h81);
    rx_wait(1);
    frm(8'h81);
    repeat (16) @(posedge clk);
    chk("done irq again", 1, dirq);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (2) @(posedge clk);
    chk("done irq serviced", 0, dirq);
    // switching off mid-frame must still let the frame out
    reg_wr(`USX_OFF_DATA, 32'h5a);
    reg_wr(`USX_OFF_CSB, 32'h70);
    chk("tx pin held", 1, txoe);
    rx_wait(1);
    frm(8'h5a);
    repeat (40) @(posedge clk);
    chk("tx pin released", 0, txoe);
    // two fifo levels plus the shift register
    for (int i = 0; i < 3; i++) rem_u.send(pk(8'h11 * (i + 1)), 9, 0);
    reg_rd(`USX_OFF_CSA);
    chk("rx flags", 32'h80, rd & 32'h98);
    for (int i = 0; i < 3; i++) begin
      reg_rd(`USX_OFF_DATA);
      chk("rx data", 8'h11 * (i + 1), rd);
    end
    reg_rd(`USX_OFF_CSA);
    chk("rx drained", 0, rd & 32'h80);
    for (int i = 3; i < 7; i++) rem_u.send(pk(8'h11 * (i + 1)), 9, 0);
    reg_rd(`USX_OFF_CSA);
    chk("no overrun yet", 0, rd & 32'h18);
    reg_rd(`USX_OFF_DATA);
    chk("rx data 4", 32'h44, rd);
    reg_rd(`USX_OFF_DATA);
    chk("rx data 5", 32'h55, rd);
    reg_rd(`USX_OFF_CSA);
    chk("overrun with char", 32'h08, rd & 32'h18);
    reg_rd(`USX_OFF_DATA);
    chk("rx data 7", 32'h77, rd);
    // double speed halves the bit time in asynchronous mode
    reg_wr(`USX_OFF_CSA, 32'h02);
    rem_u.bit_cyc = 8;
    rem_u.send(pk(8'h96), 9, 0);
    reg_rd(`USX_OFF_DATA);
    chk("double speed rx", 32'h96, rd);
    // synchronous slave keeps double speed set: it must not matter
    reg_wr(`USX_OFF_CSC, 32'h66);
    chk("slave clock pin", 0, xckoe);
    rem_u.send(pk(8'hc3), 9, 1);
    repeat (8) @(posedge clk);
    reg_rd(`USX_OFF_DATA);
    chk("sync rx", 32'hc3, rd);
    reg_wr(`USX_OFF_CSC, 32'he6);
    chk("master clock pin", 1, xckoe);
    xck_was = xcko;
    @(posedge clk);
    chk("master clock toggles", !xck_was, xcko);
    reg_wr(`USX_OFF_CSC, 32'ha6);
    chk("async clock pin", 0, xckoe);
    final_report();
  end
endmodule
